// ==== eiru_pkg.sv ====
// shared constants and types of the endpoint interrupt request unit
package eiru_pkg;
  // register byte offsets on the control bus
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_COUNT  = 12'h008;
  // control register fields (host-side enable mirror)
  localparam int CTRL_INTX_EN = 0;
  localparam int CTRL_MSI_EN  = 1;
  localparam int CTRL_MME_LSB = 2;
  localparam int CTRL_MSIX_EN = 5;
  localparam int CTRL_W       = 6;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  // status register fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_LINE_ON   = 6;
  localparam int STAT_MSI_PEND  = 7;
  localparam int STAT_MSIX_PEND = 8;
  localparam int STAT_WIDTH_LSB = 9;
  // enabled-vector codes above this one are reserved
  localparam logic [2:0] MME_MAX = 3'h5;
  // legacy line codes
  localparam logic [1:0] LINE_INTA = 2'h0;
  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  // message kinds offered to the link
  typedef enum logic [1:0] {
    KIND_INTX_ASSERT   = 2'h0,
    KIND_INTX_DEASSERT = 2'h1,
    KIND_MSI           = 2'h2,
    KIND_MSIX          = 2'h3
  } eiru_kind_type;
  // sequencer states
  typedef enum logic [5:0] {
    ST_IDLE      = 6'h01,
    ST_INTX_SEND = 6'h02,
    ST_INTX_HELD = 6'h04,
    ST_INTX_DROP = 6'h08,
    ST_MSI_SEND  = 6'h10,
    ST_MSIX_SEND = 6'h20
  } eiru_state_type;
endpackage : eiru_pkg

// ==== eiru_req_capture.sv ====
// request capture: msi edge detect and msi-x hold registers
`timescale 1ns/100ps
module eiru_req_capture
  import eiru_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // user msi request
  input  wire logic        irq_req,
  input  wire logic [4:0]  msi_vector_sel,
  input  wire logic        msi_mode,
  // user msi-x request
  input  wire logic        msix_req,
  input  wire logic [63:0] msix_address,
  input  wire logic [31:0] msix_data,
  input  wire logic        msix_on,
  // consumption by the sequencer
  input  wire logic        take_msi,
  input  wire logic        take_msix,
  // held requests
  output logic             msi_pend_q,
  output logic [4:0]       msi_vec_q,
  output logic             msix_pend_q,
  output logic [63:0]      msix_addr_q,
  output logic [31:0]      msix_data_q
);
  logic req_prev_q;
  logic msi_rise;

  // positive edge on the clock; pins are already synchronous
  assign msi_rise = irq_req & ~req_prev_q & msi_mode;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      req_prev_q <= 1'b0;
    end else begin
      req_prev_q <= irq_req;
    end
  end

  // a new edge in the take cycle stays pending: set wins
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      msi_pend_q <= 1'b0;
      msi_vec_q  <= 5'h00;
    end else if (msi_rise) begin
      msi_pend_q <= 1'b1;
      msi_vec_q  <= msi_vector_sel;
    end else if (take_msi) begin
      msi_pend_q <= 1'b0;
    end
  end

  // msi-x strobe captured only while the host enables it
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      msix_pend_q <= 1'b0;
      msix_addr_q <= 64'h0000_0000_0000_0000;
      msix_data_q <= 32'h0000_0000;
    end else if (msix_req && msix_on && !msix_pend_q) begin
      msix_pend_q <= 1'b1;
      msix_addr_q <= msix_address;
      msix_data_q <= msix_data;
    end else if (take_msix) begin
      msix_pend_q <= 1'b0;
    end
  end
endmodule : eiru_req_capture

// ==== eiru_irq_unit.sv ====
// endpoint interrupt request unit: intx/msi/msi-x toward the link
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
module eiru_irq_unit
  import eiru_pkg::*;
#(
  parameter logic [1:0] legacy_line_select = LINE_INTA
)(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // axi4-lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // user intx/msi request
  input  wire logic        irq_req,
  input  wire logic [4:0]  msi_vector_sel,
  output logic             irq_grant,
  output logic [2:0]       msi_vector_width,
  // user msi-x request
  input  wire logic        msix_req,
  input  wire logic [63:0] msix_address,
  input  wire logic [31:0] msix_data,
  output logic             msix_enable,
  output logic             msix_sent,
  output logic             msix_fail,
  // message port toward the link
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output eiru_kind_type    tx_kind,
  output logic [1:0]       tx_line,
  output logic [4:0]       tx_vector,
  output logic [63:0]      tx_addr,
  output logic [31:0]      tx_data
);
  eiru_state_type state_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [15:0]       count_q;
  logic              tx_fire;
  logic              intx_mode;
  logic              msi_mode;
  logic              msix_on;
  logic              take_msi;
  logic              take_msix;
  logic              msi_pend;
  logic [4:0]        msi_vec;
  logic              msix_pend;
  logic [63:0]       msix_addr;
  logic [31:0]       msix_dat;
  logic              line_on_q;
  logic              wr_go;
  logic [31:0]       status_w;

  // apply write strobes to one word
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  // reserved allocation codes clamp to the largest legal one
  function automatic logic [2:0] clamp_width(input logic [2:0] mme);
    return (mme > MME_MAX) ? MME_MAX : mme;
  endfunction : clamp_width

  // msi always wins over legacy when both are on
  assign msi_mode  = ctrl_q[CTRL_MSI_EN];
  assign intx_mode = ctrl_q[CTRL_INTX_EN] & ~ctrl_q[CTRL_MSI_EN];
  assign msix_on   = ctrl_q[CTRL_MSIX_EN];
  assign tx_fire   = tx_valid & tx_ready;
  assign take_msi  = (state_q == ST_MSI_SEND) & tx_fire;
  assign take_msix = (state_q == ST_MSIX_SEND) & tx_fire;

  eiru_req_capture u_capture (
    .sys_clk        (sys_clk),
    .rstn           (rstn),
    .irq_req        (irq_req),
    .msi_vector_sel (msi_vector_sel),
    .msi_mode       (msi_mode),
    .msix_req       (msix_req),
    .msix_address   (msix_address),
    .msix_data      (msix_data),
    .msix_on        (msix_on),
    .take_msi       (take_msi),
    .take_msix      (take_msix),
    .msi_pend_q     (msi_pend),
    .msi_vec_q      (msi_vec),
    .msix_pend_q    (msix_pend),
    .msix_addr_q    (msix_addr),
    .msix_data_q    (msix_dat)
  );

  // sequencer and message port; one message in flight at a time
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_q   <= ST_IDLE;
      tx_valid  <= 1'b0;
      tx_kind   <= KIND_INTX_ASSERT;
      tx_line   <= LINE_INTA;
      tx_vector <= 5'h00;
      tx_addr   <= 64'h0000_0000_0000_0000;
      tx_data   <= 32'h0000_0000;
      line_on_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (msix_pend) begin
            // msi-x is not blocked by the other modes
            state_q  <= ST_MSIX_SEND;
            tx_valid <= 1'b1;
            tx_kind  <= KIND_MSIX;
            tx_addr  <= msix_addr;
            tx_data  <= msix_dat;
          end else if (msi_pend) begin
            state_q   <= ST_MSI_SEND;
            tx_valid  <= 1'b1;
            tx_kind   <= KIND_MSI;
            tx_vector <= msi_vec;
          end else if (intx_mode && irq_req) begin
            state_q  <= ST_INTX_SEND;
            tx_valid <= 1'b1;
            tx_kind  <= KIND_INTX_ASSERT;
            tx_line  <= legacy_line_select;
          end
        end
        ST_INTX_SEND: begin
          if (tx_ready) begin
            state_q   <= ST_INTX_HELD;
            tx_valid  <= 1'b0;
            line_on_q <= 1'b1;
          end
        end
        ST_INTX_HELD: begin
          // the line stays asserted while user keeps the request
          if (msix_pend) begin
            state_q  <= ST_MSIX_SEND;
            tx_valid <= 1'b1;
            tx_kind  <= KIND_MSIX;
            tx_addr  <= msix_addr;
            tx_data  <= msix_dat;
          end else if (!irq_req) begin
            state_q  <= ST_INTX_DROP;
            tx_valid <= 1'b1;
            tx_kind  <= KIND_INTX_DEASSERT;
            tx_line  <= legacy_line_select;
          end
        end
        ST_INTX_DROP: begin
          if (tx_ready) begin
            state_q   <= ST_IDLE;
            tx_valid  <= 1'b0;
            line_on_q <= 1'b0;
          end
        end
        ST_MSI_SEND: begin
          if (tx_ready) begin
            state_q  <= ST_IDLE;
            tx_valid <= 1'b0;
          end
        end
        ST_MSIX_SEND: begin
          // resume the held legacy line if one is asserted
          if (tx_ready) begin
            state_q  <= line_on_q ? ST_INTX_HELD : ST_IDLE;
            tx_valid <= 1'b0;
          end
        end
        default: begin
          state_q  <= ST_IDLE;
          tx_valid <= 1'b0;
        end
      endcase
    end
  end

  // grant and sent pulses one cycle after the link takes a message
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      irq_grant <= 1'b0;
      msix_sent <= 1'b0;
    end else begin
      irq_grant <= tx_fire & (tx_kind != KIND_MSIX);
      msix_sent <= tx_fire & (tx_kind == KIND_MSIX);
    end
  end

  // strobe while msi-x is off, or while one is still held, fails
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      msix_fail <= 1'b0;
    end else begin
      msix_fail <= msix_req & (~msix_on | msix_pend);
    end
  end

  // host enable mirrors seen by user logic
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      msix_enable      <= 1'b0;
      msi_vector_width <= 3'h0;
    end else begin
      msix_enable <= msix_on;
      msi_vector_width <= msi_mode ?
        clamp_width(ctrl_q[CTRL_MME_LSB +: 3]) : 3'h0;
    end
  end

  // messages sent counter, wraps
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      count_q <= COUNT_RESET;
    end else if (tx_fire) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // status word
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[STAT_STATE_LSB +: 6] = state_q;
    status_w[STAT_LINE_ON]        = line_on_q;
    status_w[STAT_MSI_PEND]       = msi_pend;
    status_w[STAT_MSIX_PEND]      = msix_pend;
    status_w[STAT_WIDTH_LSB +: 3] = msi_vector_width;
  end

  // write channel: address and data taken in either order
  assign wr_go = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [31:0] ctrl_merged;

  // strobes merged into the current control word; only the low bits are kept
  assign ctrl_merged = merge_bytes({26'h000_0000, ctrl_q}, wdata_q, wstrb_q);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      awaddr_q      <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      awaddr_q      <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_axi_wready <= 1'b1;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wdata_q      <= s_axi_wdata;
      wstrb_q      <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // write commit and response; only control is writable
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl_q       <= CTRL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      if (awaddr_q[11:2] == OFS_CTRL[11:2]) begin
        ctrl_q      <= ctrl_merged[CTRL_W-1:0];
        s_axi_bresp <= RESP_OKAY;
      end else if (awaddr_q[11:2] == OFS_STATUS[11:2] ||
                   awaddr_q[11:2] == OFS_COUNT[11:2]) begin
        // read-only words ignore the write
        s_axi_bresp <= RESP_OKAY;
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel: data registered on the same edge that takes the address
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      unique case (s_axi_araddr[11:2])
        OFS_CTRL[11:2]:   s_axi_rdata <= {26'h000_0000, ctrl_q};
        OFS_STATUS[11:2]: s_axi_rdata <= status_w;
        OFS_COUNT[11:2]:  s_axi_rdata <= {16'h0000, count_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : eiru_irq_unit

// ==== eiru_irq_unit_asserts.sv ====
// concurrent checks on the interrupt request unit ports
`timescale 1ns/100ps
module eiru_irq_unit_asserts
  import eiru_pkg::*;
#(
  parameter logic [1:0] legacy_line_select = LINE_INTA
)(
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  // user side
  input  wire logic          irq_req,
  input  wire logic          irq_grant,
  input  wire logic [2:0]    msi_vector_width,
  input  wire logic          msix_req,
  input  wire logic          msix_sent,
  input  wire logic          msix_fail,
  // link side
  input  wire logic          tx_valid,
  input  wire logic          tx_ready,
  input  wire eiru_kind_type tx_kind,
  input  wire logic [1:0]    tx_line,
  input  wire logic [4:0]    tx_vector
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // the link takes a message on this edge
  wire take = tx_valid && tx_ready;
  grant_pulse_a: assert property (irq_grant |=> !irq_grant)
    else $error("grant longer than one cycle");
  grant_after_a: assert property (take && tx_kind != KIND_MSIX |=> irq_grant && !msix_sent)
    else $error("no grant after message taken");
  grant_cause_a: assert property (irq_grant |-> $past(take) && $past(tx_kind) != KIND_MSIX)
    else $error("grant without a taken message");
  sent_after_a: assert property (take && tx_kind == KIND_MSIX |=> msix_sent && !irq_grant)
    else $error("no sent pulse after msi-x taken");
  fail_cause_a: assert property (msix_fail |-> $past(msix_req))
    else $error("fail pulse without a strobe");
  line_fixed_a: assert property (tx_valid && tx_kind inside {KIND_INTX_ASSERT, KIND_INTX_DEASSERT}
    |-> tx_line == legacy_line_select)
    else $error("legacy line differs from setting");
  width_code_a: assert property (msi_vector_width <= MME_MAX)
    else $error("reserved vector width code");
  msg_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_kind) && $stable(tx_vector))
    else $error("message changed before taken");
  drop_first_a: assert property (tx_valid && tx_kind == KIND_INTX_DEASSERT |-> !irq_req)
    else $error("deassert sent while request high");
  // main scenarios reached
  cover property (take && tx_kind == KIND_INTX_DEASSERT);
  cover property (take && tx_kind == KIND_MSI);
  cover property (msix_fail);
endmodule : eiru_irq_unit_asserts

bind eiru_irq_unit eiru_irq_unit_asserts #(.legacy_line_select(legacy_line_select)) u_asserts (
  .sys_clk(sys_clk), .rstn(rstn), .irq_req(irq_req), .irq_grant(irq_grant), .msi_vector_width(msi_vector_width),
  .msix_req(msix_req), .msix_sent(msix_sent), .msix_fail(msix_fail), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_kind(tx_kind), .tx_line(tx_line), .tx_vector(tx_vector));

// ==== eiru_user_model.sv ====
// user-logic model driving the shared and msi-x request ports
`timescale 1ns/100ps
module eiru_user_model
  import eiru_pkg::*;
(
  // clock and reset
  input  wire logic   sys_clk,
  input  wire logic   rstn,
  // answer from the unit
  input  wire logic   irq_grant,
  // requests toward the unit
  output logic        irq_req,
  output logic [4:0]  msi_vector_sel,
  output logic        msix_req,
  output logic [63:0] msix_address,
  output logic [31:0] msix_data
);
  logic rearm_q;
  // quiet request lines before the first edge
  initial begin
    irq_req = 1'b0;
    msi_vector_sel = 5'h00;
    msix_req = 1'b0;
    msix_address = 64'h0000_0000_0000_0000;
    msix_data = 32'h0000_0000;
  end
  // a dropped legacy request waits for the deassert grant; one driver only
  always @(posedge sys_clk) begin
    if (!rstn) rearm_q <= 1'b1;
    else if (irq_req) rearm_q <= 1'b0;
    else if (irq_grant) rearm_q <= 1'b1;
  end
  // level request, held until dropped by the caller
  task automatic intx_raise;
    wait (rearm_q === 1'b1);
    @(posedge sys_clk);
    irq_req <= 1'b1;
  endtask : intx_raise
  task automatic intx_drop;
    @(posedge sys_clk);
    irq_req <= 1'b0;
  endtask : intx_drop
  // one-cycle pulse, then low a cycle; vector not held afterwards
  task automatic msi_pulse(input logic [4:0] vec);
    @(posedge sys_clk);
    irq_req <= 1'b1;
    msi_vector_sel <= vec;
    @(posedge sys_clk);
    irq_req <= 1'b0;
    msi_vector_sel <= ~vec;
    @(posedge sys_clk);
  endtask : msi_pulse
  // message address and data come from the user-side table
  task automatic msix_strobe(input logic [63:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    msix_req <= 1'b1;
    msix_address <= a;
    msix_data <= d;
    @(posedge sys_clk);
    msix_req <= 1'b0;
    msix_address <= ~a;
    msix_data <= ~d;
  endtask : msix_strobe
endmodule : eiru_user_model

// ==== eiru_irq_unit_test.sv ====
// self-checking bench for the interrupt request unit
`timescale 1ns/100ps
module eiru_irq_unit_test
  import eiru_pkg::*;
;
  localparam logic [1:0] LINE = 2'h2;
  logic          sys_clk, rstn, irq_grant, msix_enable, msix_sent, msix_fail, irq_req, msix_req;
  logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic          s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, tx_valid, tx_ready;
  logic [11:0]   s_axi_awaddr, s_axi_araddr;
  logic [31:0]   s_axi_wdata, s_axi_rdata, msix_data, tx_data, rdat;
  logic [3:0]    s_axi_wstrb;
  logic [1:0]    s_axi_bresp, s_axi_rresp, tx_line, resp;
  logic [4:0]    msi_vector_sel, tx_vector;
  logic [2:0]    msi_vector_width;
  logic [63:0]   msix_address, tx_addr;
  eiru_kind_type tx_kind;
  int            err_total, comparisons;

  eiru_irq_unit #(.legacy_line_select(LINE)) uut (
    .sys_clk(sys_clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_req(irq_req),
    .msi_vector_sel(msi_vector_sel), .irq_grant(irq_grant), .msi_vector_width(msi_vector_width),
    .msix_req(msix_req), .msix_address(msix_address), .msix_data(msix_data), .msix_enable(msix_enable),
    .msix_sent(msix_sent), .msix_fail(msix_fail), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_kind(tx_kind), .tx_line(tx_line), .tx_vector(tx_vector), .tx_addr(tx_addr), .tx_data(tx_data));
  eiru_user_model usr (.sys_clk(sys_clk), .rstn(rstn), .irq_grant(irq_grant), .irq_req(irq_req),
    .msi_vector_sel(msi_vector_sel), .msix_req(msix_req), .msix_address(msix_address), .msix_data(msix_data));

  // free-running system clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t %s: %h vs %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  // register write; each channel released at its own handshake
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // link side: wait, stall, take one message, judge the answer pulse
  task automatic take_msg(input eiru_kind_type k, input logic [63:0] f, input int stall);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (tx_valid !== 1'b1 && n < 60);
    repeat (stall) @(posedge sys_clk);
    chk({tx_valid, tx_kind}, {1'b1, k}, "message kind");
    if (k == KIND_MSI) chk(tx_vector, f, "vector");
    else if (k == KIND_MSIX) chk({tx_addr[31:0], tx_data}, f, "msi-x payload");
    else chk(tx_line, f, "legacy line");
    tx_ready <= 1'b1;
    @(posedge sys_clk);
    tx_ready <= 1'b0;
    @(posedge sys_clk);
    chk({irq_grant, msix_sent, tx_valid}, (k == KIND_MSIX) ? 3'b010 : 3'b100, "answer");
    @(posedge sys_clk);
    chk({irq_grant, msix_sent}, 2'b00, "pulse width");
  endtask : take_msg
  task automatic s_reset;
    rd(OFS_CTRL);
    chk({resp, rdat}, 34'h0_0000_0000, "ctrl after reset");
    rd(12'h00C);
    chk(resp, RESP_SLVERR, "unmapped read");
    wr(12'h00C, 32'hFFFF_FFFF);
    chk(resp, RESP_SLVERR, "unmapped write");
    chk({msix_enable, msi_vector_width, tx_valid}, 5'h00, "idle outputs");
  endtask : s_reset
  // legacy pairs twice, an msi-x slipped in while the line is held
  task automatic s_legacy;
    wr(OFS_CTRL, 32'h0000_0021);
    @(posedge sys_clk);
    chk(msix_enable, 1'b1, "msi-x enabled");
    for (int i = 0; i < 2; i++) begin
      usr.intx_raise();
      take_msg(KIND_INTX_ASSERT, LINE, 2);
      if (i == 0) begin
        usr.msix_strobe(64'h0000_0001_FEE0_0040, 32'h0000_5A01);
        take_msg(KIND_MSIX, 64'hFEE0_0040_0000_5A01, 1);
        chk(tx_addr, 64'h0000_0001_FEE0_0040, "msi-x address");
      end
      repeat (3) @(posedge sys_clk);
      chk(tx_valid, 1'b0, "quiet while held");
      rd(OFS_STATUS);
      chk(rdat, 32'h0000_0044, "held line status");
      usr.intx_drop();
      take_msg(KIND_INTX_DEASSERT, LINE, 0);
    end
  endtask : s_legacy
  // every width code, then msi wins over legacy with both enabled
  task automatic s_msi;
    for (int c = 0; c < 8; c++) begin
      wr(OFS_CTRL, 32'h0000_0003 | (32'(c) << CTRL_MME_LSB));
      @(posedge sys_clk);
      chk(msi_vector_width, (c > 5) ? 5 : c, "width code");
    end
    wr(OFS_CTRL, 32'h0000_0017);
    usr.msi_pulse(5'h1F);
    take_msg(KIND_MSI, 5'h1F, 3);
    usr.msi_pulse(5'h02);
    take_msg(KIND_MSI, 5'h02, 0);
  endtask : s_msi
  task automatic s_fail;
    wr(OFS_CTRL, 32'h0000_0000);
    @(posedge sys_clk);
    chk(msix_enable, 1'b0, "msi-x disabled");
    usr.msix_strobe(64'h0000_0000_0000_0010, 32'h0000_0001);
    @(posedge sys_clk);
    chk({msix_fail, tx_valid}, 2'b10, "refused strobe");
    rd(OFS_COUNT);
    chk(rdat, 32'h0000_0007, "messages sent");
  endtask : s_fail
  // reset, scenarios, verdict
  initial begin
    rstn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, tx_ready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h00_0000_0000_0000;
    s_axi_wstrb = 4'hF;
    err_total = 0;
    comparisons = 0;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    s_reset();
    s_legacy();
    s_msi();
    s_fail();
    print_verdict();
  end
  // watchdog well beyond the couple of hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    print_verdict();
  end
endmodule : eiru_irq_unit_test
